// ### rtl/stc_core.sv
/*
 * Function-command core of a parasite-powered single-line thermo sensor:
 * conversion sequencing, resolution masking, alarm compare, nonvolatile
 * limit storage, alarm-search participation and the bus line pin driver.
 * Assumes a slot-level front end that decodes command bytes into cmd_valid
 * and cmd_code, and an analog sensor that presents a 12-bit-plus-sign raw
 * sample on sensor_raw. Bit-slot timing and CRC are handled elsewhere.
 */
`timescale 1ns/1ps
`default_nettype none
`include "stc_params.svh"

module stc_core #(
    parameter logic [63:0] ROM_CODE      = 64'h0123_4567_89ab_cd01,
    // ROM_CODE value is arbitrary
    parameter int          CONV_CYCLES   = `STC_CONV_CYCLES,
    parameter int          COMMIT_CYCLES = `STC_COMMIT_CYCLES
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         cmd_valid,
    input  wire logic [7:0]   cmd_code,
    input  wire logic         pad_wr,
    input  wire logic [23:0]  pad_data,
    input  wire logic         srch_alarm,
    input  wire logic [15:0]  sensor_raw,
    input  wire logic         line_in,
    input  wire logic         tx_low,
    output logic              line_out,
    output logic              line_oe,
    output logic [15:0]       temp_out,
    output logic              alarm_out,
    output logic              busy_out,
    output logic              srch_join,
    output logic [63:0]       rom_code_out,
    output logic [23:0]       limits_out
);

    // ------------------------------------------------------------------
    // Pin input sampling
    // ------------------------------------------------------------------
    logic line_sync;

    stc_sync #(.WIDTH(1)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   (line_in),
        .dout  (line_sync)
    );

    // ------------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------------
    stc_pkg::stc_state_e  state_reg, state_next;
    stc_pkg::stc_limits_s pad_reg;
    stc_pkg::stc_limits_s nv_reg;
    stc_pkg::stc_result_s res_reg;
    logic [31:0]          timer_reg;
    logic                 nv_loaded_reg;

    wire logic is_conv_cmd   = cmd_valid && cmd_code == `STC_CMD_CONVERT;
    wire logic is_commit_cmd = cmd_valid && cmd_code == `STC_CMD_COMMIT;
    wire logic is_recall_cmd = cmd_valid && cmd_code == `STC_CMD_RECALL;
    wire logic idle          = state_reg == stc_pkg::STC_IDLE;
    wire logic timer_done    = timer_reg == 32'h0000_0001;

    // ------------------------------------------------------------------
    // Resolution masking and alarm compare
    // ------------------------------------------------------------------
    wire logic [1:0] res_sel =
        pad_reg.cfg[`STC_CFG_RES_LSB +: 2];
    wire logic [15:0] res_mask =
        16'hfff8 | (16'h0007 << (`STC_RES_12 - res_sel));
    wire logic [15:0] conv_val = sensor_raw & res_mask;
    wire logic [7:0]  whole    = conv_val[11:4];
    wire logic hi_hit = $signed(whole) >= $signed(pad_reg.upper);
    wire logic lo_hit = $signed(whole) <= $signed(pad_reg.lower);

    // Shorter resolutions finish early; the 12-bit time is the ceiling
    wire logic [31:0] conv_len =
        32'(CONV_CYCLES) >> (`STC_RES_12 - res_sel);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            stc_pkg::STC_IDLE: begin
                if (is_conv_cmd) begin
                    state_next = stc_pkg::STC_CONV;
                end else if (is_commit_cmd) begin
                    state_next = stc_pkg::STC_COMMIT;
                end else if (is_recall_cmd) begin
                    state_next = stc_pkg::STC_RECALL;
                end
            end
            stc_pkg::STC_CONV: begin
                if (timer_done) begin
                    state_next = stc_pkg::STC_IDLE;
                end
            end
            stc_pkg::STC_COMMIT: begin
                if (timer_done) begin
                    state_next = stc_pkg::STC_IDLE;
                end
            end
            stc_pkg::STC_RECALL: begin
                state_next = stc_pkg::STC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= stc_pkg::STC_IDLE;
            timer_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            if (idle && is_conv_cmd) begin
                timer_reg <= conv_len;
            end else if (idle && is_commit_cmd) begin
                timer_reg <= 32'(COMMIT_CYCLES);
            end else if (timer_reg != 32'h0) begin
                timer_reg <= timer_reg - 32'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Scratchpad, nonvolatile copy and result
    // ------------------------------------------------------------------
    // Nonvolatile copy is loaded into the scratchpad once after reset and
    // again in STC_RECALL, modelling the power-up reload of retained limits.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pad_reg       <= '{`STC_UPPER_RESET, `STC_LOWER_RESET,
                               `STC_CFG_RESET};
            nv_loaded_reg <= 1'b0;
        end else if (!nv_loaded_reg ||
                     state_reg == stc_pkg::STC_RECALL) begin
            pad_reg       <= nv_reg;
            nv_loaded_reg <= 1'b1;
        end else if (pad_wr && idle) begin
            pad_reg       <= pad_data;
        end
    end

    // Stands for the retained store: reset loads the factory contents,
    // and only a finished commit writes it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nv_reg <= '{`STC_UPPER_RESET, `STC_LOWER_RESET, `STC_CFG_RESET};
        end else if (state_reg == stc_pkg::STC_COMMIT && timer_done) begin
            nv_reg <= pad_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            res_reg <= '{`STC_TEMP_RESET, 1'b0};
        end else if (state_reg == stc_pkg::STC_CONV && timer_done) begin
            res_reg.temp  <= conv_val;
            res_reg.alarm <= hi_hit || lo_hit;
        end
    end

    // ------------------------------------------------------------------
    // Outputs and line driver
    // ------------------------------------------------------------------
    // Open drain: only ever drive low, never high; the pullup does the rest
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            line_out     <= 1'b0;
            line_oe      <= 1'b0;
            temp_out     <= `STC_TEMP_RESET;
            alarm_out    <= 1'b0;
            busy_out     <= 1'b0;
            srch_join    <= 1'b0;
            rom_code_out <= 64'h0;
            limits_out   <= 24'h0;
        end else begin
            line_out     <= 1'b0;
            line_oe      <= tx_low && idle && line_sync;
            temp_out     <= res_reg.temp;
            alarm_out    <= res_reg.alarm;
            busy_out     <= !idle || state_next != stc_pkg::STC_IDLE;
            srch_join    <= !srch_alarm || res_reg.alarm;
            rom_code_out <= ROM_CODE;
            limits_out   <= nv_reg;
        end
    end

endmodule

`default_nettype wire

// ### pkg/stc_params.svh
/*
 * Timing counts, reset values and command codes for the thermo sensor core.
 * Assumes a 40 MHz mclk; included by bare name.
 */
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH

`define STC_CLK_MHZ          40
`define STC_CONV_MAX_MS      750
`define STC_COMMIT_MS        10
`define STC_CONV_CYCLES      (`STC_CONV_MAX_MS * 1000 * `STC_CLK_MHZ)
`define STC_COMMIT_CYCLES    (`STC_COMMIT_MS * 1000 * `STC_CLK_MHZ)
`define STC_CMD_CONVERT      8'h44
`define STC_CMD_COMMIT       8'h48
`define STC_CMD_RECALL       8'hb8
`define STC_CMD_WRITE_PAD    8'h4e
`define STC_TEMP_RESET       16'h0550
`define STC_RES_12           2'h3
`define STC_CFG_RES_LSB      5
`define STC_CFG_RESET        8'h7f
`define STC_UPPER_RESET      8'h7f
`define STC_LOWER_RESET      8'h80

`endif

// ### pkg/stc_pkg.sv
/*
 * Types shared by the thermo sensor core.
 * Assumes stc_params.svh for the numeric constants.
 */
package stc_pkg;

    typedef enum logic [3:0] {
        STC_IDLE   = 4'b0001,
        STC_CONV   = 4'b0010,
        STC_COMMIT = 4'b0100,
        STC_RECALL = 4'b1000
    } stc_state_e;

    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] lower;
        logic [7:0] cfg;
    } stc_limits_s;

    typedef struct packed {
        logic [15:0] temp;
        logic        alarm;
    } stc_result_s;

endpackage

// ### rtl/stc_sync.sv
/*
 * Two-stage synchroniser for pin-level inputs.
 * Assumes the input is asynchronous to mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module stc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_reg;

    // First stage is read by the second stage only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            dout     <= '0;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// ### test/stc_checker.sv
/*
 * Port checker for stc_core, bound onto every instance.
 * Assumes the shortened conversion count of 64 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module stc_checker #(
    parameter logic [63:0] ROM_CODE = 64'h0
) (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_code,
    input wire logic        srch_alarm,
    input wire logic        tx_low,
    input wire logic        line_out,
    input wire logic        line_oe,
    input wire logic [15:0] temp_out,
    input wire logic        alarm_out,
    input wire logic        busy_out,
    input wire logic        srch_join,
    input wire logic [63:0] rom_code_out,
    input wire logic [23:0] limits_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_go;
        cmd_valid && !busy_out && (cmd_code == 8'h44 || cmd_code == 8'h48);
    endsequence
    sequence s_quiet;
        (!busy_out && !cmd_valid)[*2];
    endsequence
    a_busy_on_cmd: assert property (s_go |=> busy_out)
        else $error("busy did not follow a command");
    a_idle_hold: assert property (s_quiet |=> !busy_out)
        else $error("operation started without a command");
    // Bound suits the shortened count only
    a_op_bound: assert property (
        $rose(busy_out) |-> ##[1:80] !busy_out)
        else $error("operation ran too long");
    a_oe_busy: assert property (
        busy_out && $past(busy_out) |-> !line_oe)
        else $error("line pulled low while busy");
    a_line_low: assert property (!line_out)
        else $error("line driven high");
    a_oe_cause: assert property (line_oe |-> $past(tx_low))
        else $error("line pulled low without request");
    a_temp_hold: assert property ($changed(temp_out) && $past(rst_n)
        |-> busy_out || $past(busy_out))
        else $error("result changed outside a conversion");
    a_nv_hold: assert property ($changed(limits_out) && $past(rst_n, 2)
        |-> busy_out || $past(busy_out))
        else $error("stored limits changed outside a commit");
    a_srch_join: assert property ((srch_alarm && !busy_out)[*3]
        |-> srch_join == alarm_out)
        else $error("alarm search join wrong");
    a_rom_code: assert property (
        $past(rst_n) |-> rom_code_out == ROM_CODE)
        else $error("identity code wrong");
endmodule
bind stc_core stc_checker #(.ROM_CODE(ROM_CODE)) u_chk (
    .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .srch_alarm(srch_alarm), .tx_low(tx_low),
    .line_out(line_out), .line_oe(line_oe), .temp_out(temp_out),
    .alarm_out(alarm_out), .busy_out(busy_out), .srch_join(srch_join),
    .rom_code_out(rom_code_out), .limits_out(limits_out));
`default_nettype wire

// ### test/stc_master.sv
/*
 * Bus master with switchable strong pullup, resolving the line level.
 * Assumes the master issues commands through cmd_valid and cmd_code.
 */
`timescale 1ns/1ps
`default_nettype none
module stc_master (
    input  wire logic       mclk,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_code,
    input  wire logic       busy,
    input  wire logic       dev_oe,
    input  wire logic       mst_low,
    output var  logic       spu,
    output var  logic       line
);
    initial spu = 1'b0;
    // Strong pullup from the command edge until the device is idle
    always @(posedge mclk)
        spu <= busy || (cmd_valid && (cmd_code == 8'h44 || cmd_code == 8'h48));
    // Weak pullup; master pulls low only while the strong pullup is off
    always_comb
        line = spu || !(dev_oe || (mst_low && !spu));
endmodule
`default_nettype wire

// ### test/tb.sv
/*
 * Self-checking bench for stc_core with a master model on the line.
 * Assumes shortened conversion and commit counts.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int CONV = 64;
    logic mclk = 0, rst_n = 0, cmd_valid = 0, pad_wr = 0, srch_alarm = 0;
    logic tx_low = 0, mst_low = 0, spu, line, line_oe, alarm_out;
    logic busy_out, srch_join, line_out, al;
    logic [7:0] cmd_code = 8'h00;
    logic [15:0] sensor_raw = 16'h0000, temp_out, t;
    logic [23:0] pad_data = 24'h000000, limits_out;
    logic [63:0] rom_code_out;
    logic [31:0] seed = 32'h4ccd, r;
    int failures = 0, checked = 0;
    always #12.5 mclk = ~mclk;
    stc_master u_mst (.mclk(mclk), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .busy(busy_out), .dev_oe(line_oe),
        .mst_low(mst_low), .spu(spu), .line(line));
    stc_core #(.ROM_CODE(64'h0123_4567_89ab_cd01), .CONV_CYCLES(CONV),
        .COMMIT_CYCLES(16)) dut (.mclk(mclk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .pad_wr(pad_wr),
        .pad_data(pad_data), .srch_alarm(srch_alarm),
        .sensor_raw(sensor_raw), .line_in(line), .tx_low(tx_low),
        .line_out(line_out), .line_oe(line_oe), .temp_out(temp_out),
        .alarm_out(alarm_out), .busy_out(busy_out), .srch_join(srch_join),
        .rom_code_out(rom_code_out), .limits_out(limits_out));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input string n, input logic [63:0] s, input logic [63:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task end_sim();
        if (failures == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task load(input logic [23:0] d);
        pad_data = d;
        pad_wr = 1;
        @(negedge mclk);
        pad_wr = 0;
    endtask
    // Repeats the command mid-run; a taken repeat would stretch busy
    task run(input logic [7:0] c, input int len);
        int n;
        n = 0;
        cmd_code = c;
        cmd_valid = 1;
        for (int k = 0; k < 300 && (k < 3 || busy_out); k++) begin
            @(negedge mclk);
            if (busy_out === 1'b1) n++;
            cmd_valid = (n == 2);
            pad_wr = (n == 3);
            // A refused write must not land: offer different data
            pad_data = (n == 3) ? ~pad_data : pad_data;
        end
        pad_wr = 0;
        chk("length", n, len + 1);
        @(negedge mclk);
    endtask
    task measure(input logic [1:0] rs, input logic [7:0] u,
                 input logic [7:0] l);
        run(8'h44, CONV >> (3 - rs));
        t = sensor_raw & (16'hffff << (3 - rs));
        al = ($signed(t[11:4]) >= $signed(u)) ||
             ($signed(t[11:4]) <= $signed(l));
        chk("temp", temp_out, t);
        chk("alarm", alarm_out, al);
    endtask
    initial begin
        #(25 * 20000);
        failures++;
        end_sim();
    end
    initial begin
        logic [7:0] up, lo;
        logic [1:0] res;
        repeat (5) @(negedge mclk);
        rst_n = 1;
        repeat (2) @(negedge mclk);
        chk("temp_rst", temp_out, 16'h0550);
        chk("nv_rst", limits_out, 24'h7f807f);
        chk("rom", rom_code_out, 64'h0123_4567_89ab_cd01);
        cmd_code = 8'h4e;
        cmd_valid = 1;
        @(negedge mclk);
        cmd_valid = 0;
        repeat (20) @(negedge mclk);
        chk("idle", busy_out, 0);
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            res = i % 4;
            up = r[23:16];
            lo = r[15:8];
            tx_low = r[24];
            mst_low = r[25];
            sensor_raw = {{4{r[11]}}, r[11:0]};
            load({up, lo, 1'b0, res, 5'h1f});
            measure(res, up, lo);
            srch_alarm = r[26];
            repeat (3) @(negedge mclk);
            chk("join", srch_join, r[26] ? al : 1'b1);
            srch_alarm = 0;
        end
        r = rnd();
        load(r[23:0]);
        run(8'h48, 16);
        chk("commit", limits_out, r[23:0]);
        // Scratchpad gets another resolution; recall brings back the stored
        res = ~r[6:5];
        load({r[23:8], 1'b0, res, 5'h1f});
        cmd_code = 8'hb8;
        cmd_valid = 1;
        @(negedge mclk);
        cmd_valid = 0;
        repeat (3) @(negedge mclk);
        measure(r[6:5], r[23:16], r[15:8]);
        // Reset in mid-conversion: back to idle with the power-up result
        cmd_code = 8'h44;
        cmd_valid = 1;
        @(negedge mclk);
        cmd_valid = 0;
        repeat (4) @(negedge mclk);
        rst_n = 0;
        repeat (2) @(negedge mclk);
        rst_n = 1;
        repeat (2) @(negedge mclk);
        chk("busy_rst", busy_out, 0);
        chk("temp_rst2", temp_out, 16'h0550);
        chk("alarm_rst", alarm_out, 0);
        measure(2'h3, 8'h7f, 8'h80);
        end_sim();
    end
endmodule
`default_nettype wire
